// ===== rtl/wsc_pkg.sv
// Shared constants and types of the wiper serial control block.
// Assumes one clock domain for registers and one for the shift path.
package wsc_pkg;

    // ------------------------------------------------------------
    // Wiper word
    // ------------------------------------------------------------
    localparam logic [7:0] WSC_MIDSCALE = 8'h80;
    localparam logic [7:0] WSC_ZERO_TAP = 8'h00;

    // ------------------------------------------------------------
    // I2C target address and instruction fields
    // ------------------------------------------------------------
    localparam logic [5:0] WSC_ADDR_HI  = 6'h16;
    localparam int         WSC_RS_BIT   = 6;
    localparam int         WSC_SD_BIT   = 5;
    localparam logic [2:0] WSC_LAST_BIT = 3'h7;
    localparam logic [2:0] WSC_FIRST_BIT = 3'h0;

    // ------------------------------------------------------------
    // Pin synchroniser lanes and their idle levels
    // ------------------------------------------------------------
    localparam int         WSC_PIN_STRAP = 0;
    localparam int         WSC_PIN_CS    = 1;
    localparam int         WSC_PIN_SCL   = 2;
    localparam int         WSC_PIN_SDA   = 3;
    localparam logic [3:0] WSC_PIN_IDLE  = 4'hE;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        WSC_IDLE,
        WSC_ADDR,
        WSC_INSTR,
        WSC_DATA,
        WSC_ACK,
        WSC_READ,
        WSC_SKIP
    } wsc_i2c_st_t;

    typedef struct packed {
        logic [7:0] word;
        logic       sdo;
    } wsc_shift_t;

    typedef struct packed {
        logic [7:0] tap;
        logic       a_open;
    } wsc_term_t;

endpackage

// ===== rtl/wsc_spi_shift.sv
// Serial input register of the three-wire interface, on the link clock.
// Assumes chip select meets its setup time to the serial clock edge.
`timescale 1ns/1ns
module wsc_spi_shift (
    input  wire logic        ser_clk, // Serial clock pin, link domain
    input  wire logic        cs_n,    // Chip select, active low
    input  wire logic        sdi,     // Serial data in
    output wsc_pkg::wsc_shift_t shift // Shifted word and bit leaving
);
    import wsc_pkg::*;

    wsc_shift_t shift_reg;

    // ------------------------------------------------------------
    // Shift path
    // ------------------------------------------------------------
    // No reset: the link clock is still outside frames, and the word
    // is only read after chip select has been seen high again.
    always_ff @(posedge ser_clk) begin
        if (!cs_n) begin
            shift_reg.word <= {shift_reg.word[6:0], sdi};
            shift_reg.sdo  <= shift_reg.word[7];
        end
    end

    assign shift = shift_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Only bits already shifted are checked: the word powers up unknown.
    property p_shift_in;
        @(posedge ser_clk) disable iff (cs_n)
        !cs_n |=> shift_reg.word[0] == $past(sdi);
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("serial input bit not taken on clock rise");

    property p_keep_last;
        @(posedge ser_clk) disable iff (cs_n)
        !cs_n [*8] |=> shift_reg.word ==
            {$past(sdi, 8), $past(sdi, 7), $past(sdi, 6), $past(sdi, 5),
             $past(sdi, 4), $past(sdi, 3), $past(sdi, 2), $past(sdi, 1)};
    endproperty
    a_keep_last: assert property (p_keep_last)
        else $error("word is not the last eight bits shifted in");

endmodule

// ===== rtl/wsc_top.sv
// Serial control of a 256-tap potentiometer wiper: three-wire shift
// port or I2C target, chosen by a strap pin.
// Assumes SCL no faster than 400 kHz against the 10 MHz ref_clk and
// board pull-ups on both open-drain lines.
`timescale 1ns/1ns
module wsc_top (
    input  wire logic       ref_clk,          // 10 MHz system clock
    input  wire logic       resetn,           // Sync reset, active low
    input  wire logic       ser_clk,          // CLK/SCL pin, link clock
    input  wire logic       cs_n,             // Chip select or addr pin
    input  wire logic       sdi_sda_i,        // SDI or SDA level
    input  wire logic       interface_select, // Strap, high for I2C
    output logic            sda_o,            // SDA drive value
    output logic            sda_oe,           // SDA pulled low when high
    output logic            sdo_o,            // SDO drive value
    output logic            sdo_oe,           // SDO pulled low when high
    output logic [7:0]      wiper_value,      // Stored wiper code
    output wsc_pkg::wsc_term_t term           // Tap and A-terminal state
);
    import wsc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [3:0]  pins;
    logic [3:0]  sync1_reg;
    logic [3:0]  sync2_reg;
    logic [3:0]  dly_reg;
    wsc_shift_t  shift;
    logic        spi_mode;
    logic        address_select_pin;
    logic        cs_rise;
    logic        scl_rise;
    logic        scl_fall;
    logic        scl_hi;
    logic        sda_s;
    logic        i2c_start;
    logic        i2c_stop;
    logic        spi_load;
    logic        frame_seen_reg;
    logic [7:0]  wiper_reg;
    logic        shutdown_reg;
    wsc_term_t   term_reg;
    wsc_i2c_st_t st_reg;
    wsc_i2c_st_t ret_reg;
    logic [2:0]  bit_reg;
    logic [7:0]  byte_reg;
    logic [7:0]  instr_reg;
    logic        sda_oe_reg;
    logic [7:0]  byte_full;
    logic        rx_state;
    logic        byte_end;
    logic        addr_match;
    logic        instr_done;
    logic        data_done;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic rose(input logic now, input logic prev);
        rose = now & ~prev;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pins = {sdi_sda_i, ser_clk, cs_n, interface_select};

    // Edge detectors look only at the second stage and its delay.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sync1_reg <= WSC_PIN_IDLE;
            sync2_reg <= WSC_PIN_IDLE;
            dly_reg   <= WSC_PIN_IDLE;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            dly_reg   <= sync2_reg;
        end
    end

    assign spi_mode = ~sync2_reg[WSC_PIN_STRAP];
    assign address_select_pin = sync2_reg[WSC_PIN_CS];
    assign sda_s    = sync2_reg[WSC_PIN_SDA];
    assign scl_hi   = sync2_reg[WSC_PIN_SCL] & dly_reg[WSC_PIN_SCL];
    assign cs_rise  = rose(sync2_reg[WSC_PIN_CS], dly_reg[WSC_PIN_CS]);
    assign scl_rise = rose(sync2_reg[WSC_PIN_SCL], dly_reg[WSC_PIN_SCL]);
    assign scl_fall = rose(dly_reg[WSC_PIN_SCL], sync2_reg[WSC_PIN_SCL]);
    assign i2c_start = scl_hi & rose(dly_reg[WSC_PIN_SDA], sda_s);
    assign i2c_stop  = scl_hi & rose(sda_s, dly_reg[WSC_PIN_SDA]);

    // ------------------------------------------------------------
    // Shift port on the link clock
    // ------------------------------------------------------------
    wsc_spi_shift u_shift (
        .ser_clk (ser_clk),
        .cs_n    (cs_n),
        .sdi     (sdi_sda_i),
        .shift   (shift)
    );

    // Word is still once chip select is high: safe to take across.
    assign spi_load = spi_mode & cs_rise;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            frame_seen_reg <= 1'b0;
        end else if (spi_mode & ~address_select_pin) begin
            frame_seen_reg <= 1'b1;
        end
    end

    // Daisy-chain output; held off until chip select has first been seen low in shift mode.
    assign sdo_o  = 1'b0;
    assign sdo_oe = spi_mode & frame_seen_reg & ~shift.sdo;

    // ------------------------------------------------------------
    // I2C byte decode
    // ------------------------------------------------------------
    assign byte_full  = {byte_reg[6:0], sda_s};
    assign rx_state   = (st_reg == WSC_ADDR) |
                        (st_reg == WSC_INSTR) |
                        (st_reg == WSC_DATA);
    assign byte_end   = scl_rise & rx_state &
                        (bit_reg == WSC_LAST_BIT) & ~spi_mode;
    assign addr_match = byte_full[7:1] ==
                        {WSC_ADDR_HI, address_select_pin};
    assign instr_done = byte_end & (st_reg == WSC_INSTR);
    assign data_done  = byte_end & (st_reg == WSC_DATA);

    // ------------------------------------------------------------
    // I2C target engine
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn || spi_mode) begin
            st_reg     <= WSC_IDLE;
            ret_reg    <= WSC_IDLE;
            bit_reg    <= WSC_FIRST_BIT;
            byte_reg   <= WSC_ZERO_TAP;
            sda_oe_reg <= 1'b0;
        end else if (i2c_start) begin
            st_reg     <= WSC_ADDR;
            bit_reg    <= WSC_FIRST_BIT;
            sda_oe_reg <= 1'b0;
        end else if (i2c_stop) begin
            st_reg     <= WSC_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            case (st_reg)
                WSC_ADDR, WSC_INSTR, WSC_DATA: begin
                    if (scl_rise) begin
                        byte_reg <= byte_full;
                        bit_reg  <= bit_reg + 3'h1;
                    end
                    if (byte_end) begin
                        if (st_reg == WSC_ADDR && !addr_match) begin
                            st_reg <= WSC_SKIP;
                        end else begin
                            st_reg <= WSC_ACK;
                        end
                        case (st_reg)
                            WSC_ADDR: begin
                                ret_reg <= byte_full[0] ?
                                           WSC_READ : WSC_INSTR;
                            end
                            WSC_INSTR: begin
                                ret_reg <= WSC_DATA;
                            end
                            default: begin
                                ret_reg <= WSC_SKIP;
                            end
                        endcase
                    end
                end
                WSC_ACK: begin
                    if (scl_fall) begin
                        if (!sda_oe_reg) begin
                            sda_oe_reg <= 1'b1;
                        end else begin
                            st_reg  <= ret_reg;
                            bit_reg <= WSC_FIRST_BIT;
                            if (ret_reg == WSC_READ) begin
                                byte_reg   <= wiper_reg;
                                sda_oe_reg <= ~wiper_reg[7];
                            end else begin
                                sda_oe_reg <= 1'b0;
                            end
                        end
                    end
                end
                WSC_READ: begin
                    // One byte per read; host acknowledge ignored.
                    if (scl_fall) begin
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == WSC_LAST_BIT) begin
                            sda_oe_reg <= 1'b0;
                            st_reg     <= WSC_SKIP;
                        end else begin
                            byte_reg   <= {byte_reg[6:0], 1'b0};
                            sda_oe_reg <= ~byte_reg[6];
                        end
                    end
                end
                WSC_IDLE, WSC_SKIP: begin
                    sda_oe_reg <= 1'b0;
                end
                default: begin
                    st_reg     <= WSC_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    assign sda_o  = 1'b0;
    assign sda_oe = sda_oe_reg;

    // ------------------------------------------------------------
    // Instruction latch and shutdown
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            instr_reg <= WSC_ZERO_TAP;
        end else if (instr_done) begin
            instr_reg <= byte_full;
        end
    end

    // Shutdown only steers the terminals, never the stored code.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            shutdown_reg <= 1'b0;
        end else if (instr_done) begin
            shutdown_reg <= byte_full[WSC_SD_BIT];
        end
    end

    // ------------------------------------------------------------
    // Wiper register
    // ------------------------------------------------------------
    // Reset acts at instruction time, even if the data byte is cut.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wiper_reg <= WSC_MIDSCALE;
        end else if (spi_load) begin
            wiper_reg <= shift.word;
        end else if (instr_done && byte_full[WSC_RS_BIT]) begin
            wiper_reg <= WSC_MIDSCALE;
        end else if (data_done && !instr_reg[WSC_RS_BIT]) begin
            wiper_reg <= byte_full;
        end
    end

    assign wiper_value = wiper_reg;

    // ------------------------------------------------------------
    // Terminal drive
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            term_reg.tap    <= WSC_MIDSCALE;
            term_reg.a_open <= 1'b0;
        end else if (shutdown_reg) begin
            term_reg.tap    <= WSC_ZERO_TAP;
            term_reg.a_open <= 1'b1;
        end else begin
            term_reg.tap    <= wiper_reg;
            term_reg.a_open <= 1'b0;
        end
    end

    assign term = term_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    sequence s_instr_rs;
        instr_done && byte_full[WSC_RS_BIT];
    endsequence
    sequence s_ack_begin;
        st_reg == WSC_ACK && scl_fall && !sda_oe_reg && !i2c_start
            && !i2c_stop && !spi_mode;
    endsequence

    property p_power_on_mid;
        $rose(resetn) |-> wiper_reg == WSC_MIDSCALE;
    endproperty
    a_power_on_mid: assert property (p_power_on_mid)
        else $error("wiper not at midscale after reset");
    property p_spi_load;
        spi_load |=> wiper_reg == $past(shift.word);
    endproperty
    a_spi_load: assert property (p_spi_load)
        else $error("shift word not loaded on chip select rise");
    property p_i2c_ignores_cs;
        !spi_mode && !instr_done && !data_done |=> $stable(wiper_reg);
    endproperty
    a_i2c_ignores_cs: assert property (p_i2c_ignores_cs)
        else $error("wiper changed in I2C mode without a write");
    property p_rs_mid;
        s_instr_rs |=> wiper_reg == WSC_MIDSCALE ##1
            term_reg.tap == (shutdown_reg ? WSC_ZERO_TAP : WSC_MIDSCALE);
    endproperty
    a_rs_mid: assert property (p_rs_mid)
        else $error("reset bit did not recentre the wiper");
    property p_sd_keeps;
        instr_done && !byte_full[WSC_RS_BIT] |=> $stable(wiper_reg);
    endproperty
    a_sd_keeps: assert property (p_sd_keeps)
        else $error("instruction byte altered the wiper");
    property p_sd_clear;
        instr_done |=> shutdown_reg == $past(byte_full[WSC_SD_BIT]);
    endproperty
    a_sd_clear: assert property (p_sd_clear)
        else $error("shutdown bit not followed");
    property p_shutdown_term;
        shutdown_reg |=> term_reg.tap == WSC_ZERO_TAP && term_reg.a_open;
    endproperty
    a_shutdown_term: assert property (p_shutdown_term)
        else $error("shutdown did not park wiper at B with A open");
    property p_tap_code;
        !shutdown_reg |=> term_reg.tap == $past(wiper_reg) && !term_reg.a_open;
    endproperty
    a_tap_code: assert property (p_tap_code)
        else $error("tap does not follow the wiper code");
    property p_addr_reject;
        byte_end && st_reg == WSC_ADDR && !addr_match && !i2c_start
            && !i2c_stop |=> st_reg == WSC_SKIP && !sda_oe_reg;
    endproperty
    a_addr_reject: assert property (p_addr_reject)
        else $error("foreign address was not ignored");
    property p_ack;
        s_ack_begin |=> sda_oe_reg && st_reg == WSC_ACK;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge not driven after a byte");
    property p_read_bit;
        st_reg == WSC_READ |-> sda_oe_reg == ~byte_reg[7];
    endproperty
    a_read_bit: assert property (p_read_bit)
        else $error("read bit on SDA differs from wiper byte");
    property p_open_drain;
        sda_oe |-> !spi_mode ##0 sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("SDA driven outside I2C mode");

endmodule

// ===== dv/wsc_host.sv
// Host controller model: drives the shift port and the I2C lines.
// Assumes the bench ties its outputs to the device and wraps its tasks.
`timescale 1ns/1ns
module wsc_host (
    output logic       ser_clk,   // CLK/SCL, still between frames
    output logic       cs_n,      // Chip select or address pin
    output logic       sdi_sda_i, // Data wire level at the device
    input  wire logic  sda_oe,    // Device pulls SDA low
    input  wire logic  sdo_oe,    // Device pulls SDO low
    output logic       sdo_line   // SDO wire level
);
    localparam int Q = 700;
    logic sd_host;

    // --------------------------------------------------------
    // Wires with board pull-ups
    // --------------------------------------------------------
    assign sdi_sda_i = sd_host & ~sda_oe;
    assign sdo_line  = ~sdo_oe;

    initial begin
        ser_clk = 1'b1;
        cs_n    = 1'b1;
        sd_host = 1'b1;
    end

    // --------------------------------------------------------
    // Shift port frame
    // --------------------------------------------------------
    task automatic spi(input logic [11:0] w, input int n);
        cs_n = 1'b0;
        #Q;
        for (int i = n - 1; i >= 0; i--) begin
            ser_clk = 1'b0;
            sd_host = w[i];
            #16;
            ser_clk = 1'b1;
            #16;
        end
        #Q;
        cs_n = 1'b1;
        // Released line: inverse of last bit, no pull on SDI
        sd_host = ~sd_host;
        #1000;
    endtask

    // --------------------------------------------------------
    // I2C conditions and bits, 357 kHz
    // --------------------------------------------------------
    task automatic start();
        sd_host = 1'b1;
        ser_clk = 1'b1;
        #Q;
        sd_host = 1'b0;
        #Q;
        ser_clk = 1'b0;
        #Q;
    endtask

    task automatic stop();
        sd_host = 1'b0;
        #Q;
        ser_clk = 1'b1;
        #Q;
        sd_host = 1'b1;
        #(4 * Q);
    endtask

    task automatic bit_io(input logic b, output logic r);
        sd_host = b;
        #Q;
        ser_clk = 1'b1;
        #Q;
        r = sdi_sda_i;
        #Q;
        ser_clk = 1'b0;
        #Q;
    endtask

    // Ack bit always released by host: NACK after a read byte
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'b1, ack);
    endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench of the wiper serial control block.
// Assumes the host model drives the link side; 10 MHz ref_clk.
`timescale 1ns/1ns
module testbench;
    import wsc_pkg::*;
    logic             ref_clk;
    logic             resetn;
    logic             interface_select;
    logic             ser_clk;
    logic             cs_n;
    logic             sdi_sda_i;
    logic             sdo_line;
    logic             sda_o;
    logic             sda_oe;
    logic             sdo_o;
    logic             sdo_oe;
    logic [7:0]       wiper_value;
    logic [7:0]       rx;
    logic             ack;
    wsc_term_t        term;
    int               n_fail = 0;
    int               cmp_count = 0;
    int               cycles = 0;

    wsc_top uut (.ref_clk(ref_clk), .resetn(resetn), .ser_clk(ser_clk),
        .cs_n(cs_n), .sdi_sda_i(sdi_sda_i),
        .interface_select(interface_select), .sda_o(sda_o),
        .sda_oe(sda_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .wiper_value(wiper_value), .term(term));

    wsc_host host (.ser_clk(ser_clk), .cs_n(cs_n), .sdi_sda_i(sdi_sda_i),
        .sda_oe(sda_oe), .sdo_oe(sdo_oe), .sdo_line(sdo_line));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // --------------------------------------------------------
    // Compare, verdict and hang guard
    // --------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            results();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] ins,
                      input logic [7:0] d, input logic ok);
        host.start();
        host.xfer(a, rx, ack);
        check({8'h00, ack}, {8'h00, ~ok});
        if (ok) begin
            host.xfer(ins, rx, ack);
            check({8'h00, ack}, 9'h000);
            host.xfer(d, rx, ack);
            check({8'h00, ack}, 9'h000);
        end
        host.stop();
    endtask

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        resetn = 1'b0;
        interface_select = 1'b0;
        repeat (16) @(negedge ref_clk);
        check({1'b0, wiper_value}, 9'h080);
        check(term, {8'h80, 1'b0});
        check({5'h00, sda_oe, sdo_oe, sda_o, sdo_o}, 9'h000);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        host.spi(12'h05A, 8);
        check({1'b0, wiper_value}, 9'h05A);
        check(term, {8'h5A, 1'b0});
        host.spi(12'h0C3, 9);
        check({1'b0, wiper_value}, 9'h0C3);
        check({7'h00, sdo_line, sdo_o}, 9'h000);
        host.spi(12'hF3C, 12);
        check({1'b0, wiper_value}, 9'h03C);
        check({8'h00, sdo_line}, 9'h001);
        @(negedge ref_clk);
        interface_select = 1'b1;
        host.cs_n = 1'b0;
        #2000;
        wr(8'h5A, 8'h00, 8'h00, 1'b0);
        check({1'b0, wiper_value}, 9'h03C);
        wr(8'h58, 8'h9F, 8'h21, 1'b1);
        check({1'b0, wiper_value}, 9'h021);
        wr(8'h58, 8'h20, 8'h21, 1'b1);
        check(term, {8'h00, 1'b1});
        check({1'b0, wiper_value}, 9'h021);
        host.start();
        host.xfer(8'h59, rx, ack);
        check({8'h00, ack}, 9'h000);
        host.xfer(8'hFF, rx, ack);
        check({1'b0, rx}, 9'h021);
        host.stop();
        wr(8'h58, 8'h40, 8'h55, 1'b1);
        check({1'b0, wiper_value}, 9'h080);
        check(term, {8'h80, 1'b0});
        host.cs_n = 1'b1;
        wr(8'h5A, 8'h00, 8'h66, 1'b1);
        check({1'b0, wiper_value}, 9'h066);
        results();
    end
endmodule
